// [shared/pofs_params.svh]
// Offsets, field positions, reset values and timing counts for the power-off sequencer.
// Assumes inclusion by bare name from every file that needs these constants.
//
// Function
// - Step two runs only when its execute bit 7 is set; default set.
// - Executing step two disables switchers selected by bits 6, 4, 3.
// - After step two, idle for bits 2:0 milliseconds; default one.
// - Step three runs only when its execute bit 7 is set; default clear.
// - Executing step three disables switchers selected by bits 6, 4, 3.
// - After step three, idle for bits 2:0 milliseconds; default zero.
// - Switcher A ramp time after enable comes from bits 7:5; default code one.
// - Switcher B ramp time uses bits 7:5 with the same mapping.
// - Switcher C ramp time uses bits 3:1 of that register; default one.
// - The two reserved bytes after step three read as zero.
// - Step one has the same layout and runs before step two.
`ifndef POFS_PARAMS_SVH
`define POFS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
`define POFS_ADDR_STEP_ONE    8'h58
`define POFS_ADDR_STEP_TWO    8'h59
`define POFS_ADDR_STEP_THREE  8'h5a
`define POFS_ADDR_RSVD_A      8'h5b
`define POFS_ADDR_RSVD_B      8'h5c
`define POFS_ADDR_RAMP_A      8'h5d
`define POFS_ADDR_RAMP_BC     8'h5e

// ----------------------------------------------------------------------------
// Field positions and writable masks.
// ----------------------------------------------------------------------------
`define POFS_BIT_EXEC         7
`define POFS_BIT_DIS_A        6
`define POFS_BIT_DIS_B        4
`define POFS_BIT_DIS_C        3
`define POFS_IDLE_MSB         2
`define POFS_IDLE_LSB         0
`define POFS_RAMP_A_MSB       7
`define POFS_RAMP_A_LSB       5
`define POFS_RAMP_B_MSB       7
`define POFS_RAMP_B_LSB       5
`define POFS_RAMP_C_MSB       3
`define POFS_RAMP_C_LSB       1
`define POFS_MASK_STEP        8'hdf
`define POFS_MASK_RAMP_A      8'he0
`define POFS_MASK_RAMP_BC     8'hee

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define POFS_RST_STEP_ONE     8'hd1
`define POFS_RST_STEP_TWO     8'hd9
`define POFS_RST_STEP_THREE   8'h00
`define POFS_RST_RAMP_A       8'h20
`define POFS_RST_RAMP_BC      8'h22

// ----------------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------------
`define POFS_MS_TIME_NS       1000000
`define POFS_CLK_PERIOD_NS    4
`define POFS_MS_CYCLES        (`POFS_MS_TIME_NS / `POFS_CLK_PERIOD_NS)

`endif

// [shared/pofs_pkg.sv]
// Types shared by the power-off sequencer and its timers.
// Assumes the constants header is compiled alongside.
package pofs_pkg;

    typedef logic [7:0] pofs_byte_t;
    typedef logic [3:0] pofs_ms_t;
    typedef logic [2:0] pofs_sw_t;
    typedef logic [1:0] pofs_idx_t;

    typedef enum logic [1:0] {
        POFS_IDLE,
        POFS_EVAL,
        POFS_WAIT
    } pofs_state_t;

endpackage : pofs_pkg

// [rtl/pofs_ms_timer.sv]
// Millisecond countdown timer with a start pulse and a one-cycle done pulse.
// Assumes start comes from logic on sys_clk.
`timescale 1ns/1ps
`include "pofs_params.svh"
module pofs_ms_timer
    import pofs_pkg::*;
#(
    parameter int MS_CYCLES = `POFS_MS_CYCLES
) (
    input  wire logic     sys_clk,
    input  wire logic     rst_n,
    input  wire logic     start,
    input  wire pofs_ms_t ms_count,
    output logic          busy,
    output logic          done
);

    localparam int PW = $clog2(MS_CYCLES + 1);

    logic [PW-1:0] pre_q;
    pofs_ms_t      left_q;

    // ------------------------------------------------------------------------
    // Countdown of whole milliseconds.
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy   <= 1'b0;
            done   <= 1'b0;
            pre_q  <= '0;
            left_q <= 4'h0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy   <= 1'b1;
                pre_q  <= '0;
                left_q <= ms_count;
            end else if (busy) begin
                if (left_q == 4'h0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else if (pre_q == PW'(MS_CYCLES - 1)) begin
                    pre_q  <= '0;
                    left_q <= left_q - 4'h1;
                end else begin
                    pre_q <= pre_q + PW'(1);
                end
            end
        end
    end

endmodule : pofs_ms_timer

// [rtl/pofs_top.sv]
// Power-off sequencer with three steps and per-switcher soft-start timing.
// Assumes the serial interface delivers byte accesses on sys_clk as strobes.
`timescale 1ns/1ps
`include "pofs_params.svh"
module pofs_top
    import pofs_pkg::*;
#(
    parameter int MS_CYCLES = `POFS_MS_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire pofs_byte_t reg_addr,
    input  wire pofs_byte_t reg_wdata,
    output pofs_byte_t      reg_rdata_q,
    input  wire logic       power_off_req,
    input  wire pofs_sw_t   sw_on_req,
    output pofs_sw_t        sw_en_q,
    output pofs_sw_t        sw_ramping,
    output pofs_sw_t        sw_ready_q,
    output logic            seq_busy_q,
    output logic            seq_done_q
);

    pofs_byte_t  step_q [3];
    pofs_byte_t  ramp_a_q;
    pofs_byte_t  ramp_bc_q;
    pofs_state_t state_q;
    pofs_idx_t   idx_q;
    pofs_sw_t    req_prev_q;
    pofs_sw_t    ramp_start;
    pofs_sw_t    ramp_done;
    pofs_byte_t  cur_step;
    pofs_sw_t    cur_sel;
    logic        cur_exec;
    logic        tmr_start;
    logic        tmr_done;
    logic [2:0]  ramp_code [3];
    pofs_ms_t    ramp_ms [3];

    function automatic pofs_ms_t ramp_ms_of(input logic [2:0] code);
        ramp_ms_of = (code == 3'h0) ? 4'h1 : {code, 1'b0};
    endfunction : ramp_ms_of

    // ------------------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_q[0] <= `POFS_RST_STEP_ONE;
            step_q[1] <= `POFS_RST_STEP_TWO;
            step_q[2] <= `POFS_RST_STEP_THREE;
            ramp_a_q  <= `POFS_RST_RAMP_A;
            ramp_bc_q <= `POFS_RST_RAMP_BC;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `POFS_ADDR_STEP_ONE:   step_q[0] <= reg_wdata & `POFS_MASK_STEP;
                `POFS_ADDR_STEP_TWO:   step_q[1] <= reg_wdata & `POFS_MASK_STEP;
                `POFS_ADDR_STEP_THREE: step_q[2] <= reg_wdata & `POFS_MASK_STEP;
                `POFS_ADDR_RAMP_A:     ramp_a_q  <= reg_wdata & `POFS_MASK_RAMP_A;
                `POFS_ADDR_RAMP_BC:    ramp_bc_q <= reg_wdata & `POFS_MASK_RAMP_BC;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Register reads.
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `POFS_ADDR_STEP_ONE:   reg_rdata_q <= step_q[0];
                `POFS_ADDR_STEP_TWO:   reg_rdata_q <= step_q[1];
                `POFS_ADDR_STEP_THREE: reg_rdata_q <= step_q[2];
                `POFS_ADDR_RAMP_A:     reg_rdata_q <= ramp_a_q;
                `POFS_ADDR_RAMP_BC:    reg_rdata_q <= ramp_bc_q;
                default:               reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Current step decode.
    // ------------------------------------------------------------------------
    always_comb begin
        cur_step = step_q[idx_q];
        cur_exec = cur_step[`POFS_BIT_EXEC];
        cur_sel  = {cur_step[`POFS_BIT_DIS_C], cur_step[`POFS_BIT_DIS_B], cur_step[`POFS_BIT_DIS_A]};
    end

    assign tmr_start = (state_q == POFS_EVAL) && cur_exec;

    // ------------------------------------------------------------------------
    // Step sequencer.
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= POFS_IDLE;
            idx_q      <= 2'h0;
            seq_busy_q <= 1'b0;
            seq_done_q <= 1'b0;
        end else begin
            seq_done_q <= 1'b0;
            case (state_q)
                POFS_IDLE: begin
                    if (power_off_req) begin
                        state_q    <= POFS_EVAL;
                        idx_q      <= 2'h0;
                        seq_busy_q <= 1'b1;
                    end
                end
                POFS_EVAL: begin
                    if (cur_exec) begin
                        state_q <= POFS_WAIT;
                    end else if (idx_q == 2'h2) begin
                        state_q    <= POFS_IDLE;
                        seq_busy_q <= 1'b0;
                        seq_done_q <= 1'b1;
                    end else begin
                        idx_q <= idx_q + 2'h1;
                    end
                end
                POFS_WAIT: begin
                    if (tmr_done) begin
                        if (idx_q == 2'h2) begin
                            state_q    <= POFS_IDLE;
                            seq_busy_q <= 1'b0;
                            seq_done_q <= 1'b1;
                        end else begin
                            state_q <= POFS_EVAL;
                            idx_q   <= idx_q + 2'h1;
                        end
                    end
                end
                default: begin
                    state_q    <= POFS_IDLE;
                    seq_busy_q <= 1'b0;
                end
            endcase
        end
    end

    pofs_ms_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_idle_timer (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .start    (tmr_start),
        .ms_count ({1'b0, cur_step[`POFS_IDLE_MSB:`POFS_IDLE_LSB]}),
        .busy     (),
        .done     (tmr_done)
    );

    // ------------------------------------------------------------------------
    // Switcher enables and soft-start.
    // ------------------------------------------------------------------------
    assign ramp_start = sw_on_req & ~req_prev_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_prev_q <= 3'h0;
            sw_en_q    <= 3'h0;
            sw_ready_q <= 3'h0;
        end else begin
            req_prev_q <= sw_on_req;
            if (tmr_start) begin
                sw_en_q    <= (sw_en_q | ramp_start) & sw_on_req & ~cur_sel;
                sw_ready_q <= sw_ready_q & sw_on_req & ~cur_sel & ~ramp_start;
            end else begin
                sw_en_q    <= (sw_en_q | ramp_start) & sw_on_req;
                sw_ready_q <= (sw_ready_q | ramp_done) & sw_on_req & ~ramp_start;
            end
        end
    end

    assign ramp_code[0] = ramp_a_q[`POFS_RAMP_A_MSB:`POFS_RAMP_A_LSB];
    assign ramp_code[1] = ramp_bc_q[`POFS_RAMP_B_MSB:`POFS_RAMP_B_LSB];
    assign ramp_code[2] = ramp_bc_q[`POFS_RAMP_C_MSB:`POFS_RAMP_C_LSB];

    for (genvar g = 0; g < 3; g++) begin : g_ramp
        assign ramp_ms[g] = ramp_ms_of(ramp_code[g]);
        pofs_ms_timer #(
            .MS_CYCLES (MS_CYCLES)
        ) u_ramp_timer (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .start    (ramp_start[g]),
            .ms_count (ramp_ms[g]),
            .busy     (sw_ramping[g]),
            .done     (ramp_done[g])
        );
    end

    // ------------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------------
    a_step_two_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == POFS_EVAL && idx_q == 2'h1 && step_q[1][7]) |=> state_q == POFS_WAIT)
        else $error("Step two did not run.");
    a_step_two_skip: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == POFS_EVAL && idx_q == 2'h1 && !step_q[1][7]) |=> (state_q == POFS_EVAL && idx_q == 2'h2))
        else $error("Step two was not skipped.");
    a_step_two_dis: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == POFS_EVAL && idx_q == 2'h1 && step_q[1][7] && step_q[1][6]) |=> !sw_en_q[0])
        else $error("Switcher A not disabled by step two.");
    a_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == POFS_EVAL && step_q[idx_q][7] && step_q[idx_q][2:0] == 3'h0) |=> state_q == POFS_WAIT ##2
        state_q != POFS_WAIT || idx_q != $past(idx_q, 3))
        else $error("Zero idle time did not end at once.");
    a_step_three_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == POFS_EVAL && idx_q == 2'h2 && !step_q[2][7]) |=> (state_q == POFS_IDLE && seq_done_q))
        else $error("Disabled step three did not finish the sequence.");
    a_step_three_dis: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == POFS_EVAL && idx_q == 2'h2 && step_q[2][7] && step_q[2][3]) |=> !sw_en_q[2])
        else $error("Switcher C not disabled by step three.");
    a_ramp_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(sw_en_q[0]) |-> sw_ramping[0] && !sw_ready_q[0])
        else $error("Switcher A enabled without ramp.");
    a_rsvd_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_rd_en && (reg_addr == 8'h5b || reg_addr == 8'h5c)) |=> reg_rdata_q == 8'h00)
        else $error("Reserved byte read nonzero.");
    a_seq_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == POFS_WAIT && idx_q == 2'h0 && tmr_done) |=> (state_q == POFS_EVAL && idx_q == 2'h1))
        else $error("Step one did not lead to step two.");

endmodule : pofs_top

// [sim/pofs_tb.sv]
// Self-checking bench for the power-off sequencer, its registers and soft-start timing.
// Assumes MS_CYCLES is shortened to 10 and that every input changes on the falling clock edge.
`timescale 1ns/1ps
`include "pofs_params.svh"
module power_off_sequence_and_soft_start_cfg_test;
    import pofs_pkg::*;

    localparam int MSC   = 10;
    localparam int LIMIT = 60000;

    logic       sys_clk;
    logic       rst_n;
    logic       reg_wr_en;
    logic       reg_rd_en;
    logic       power_off_req;
    pofs_byte_t reg_addr;
    pofs_byte_t reg_wdata;
    pofs_byte_t reg_rdata_q;
    pofs_sw_t   sw_on_req;
    pofs_sw_t   sw_en_q;
    pofs_sw_t   sw_ramping;
    pofs_sw_t   sw_ready_q;
    logic       seq_busy_q;
    logic       seq_done_q;
    int         n_mismatch;
    int         checks;
    int         cyc;
    int         mdl [256];
    int         ms_tab [8] = '{1, 2, 4, 6, 8, 10, 12, 14};

    pofs_top #(.MS_CYCLES(MSC)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .power_off_req(power_off_req), .sw_on_req(sw_on_req), .sw_en_q(sw_en_q),
        .sw_ramping(sw_ramping), .sw_ready_q(sw_ready_q), .seq_busy_q(seq_busy_q),
        .seq_done_q(seq_done_q)
    );

    // ------------------------------------------------------------------------
    // Compare and report.
    // ------------------------------------------------------------------------
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_byte

    task automatic cmp_cnt(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_cnt

    task automatic final_report;
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------------
    // Register model and bus tasks.
    // ------------------------------------------------------------------------
    function automatic int msk(input int a);
        case (a)
            8'h58, 8'h59, 8'h5a: return 8'hdf;
            8'h5d: return 8'he0;
            8'h5e: return 8'hee;
            default: return 0;
        endcase
    endfunction : msk

    task automatic mdl_reset;
        foreach (mdl[i]) mdl[i] = 0;
        mdl[8'h58] = 8'hd1;
        mdl[8'h59] = 8'hd9;
        mdl[8'h5d] = 8'h20;
        mdl[8'h5e] = 8'h22;
    endtask : mdl_reset

    task automatic wr(input pofs_byte_t a, input pofs_byte_t d);
        reg_wr_en = 1'b1;
        reg_rd_en = 1'b0;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge sys_clk);
        mdl[a] = d & msk(a);
    endtask : wr

    task automatic idle;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        @(negedge sys_clk);
    endtask : idle

    task automatic check_regs;
        for (int a = 8'h57; a <= 8'h5f; a++) begin
            reg_rd_en = 1'b1;
            reg_wr_en = 1'b0;
            reg_addr  = pofs_byte_t'(a);
            @(negedge sys_clk);
            cmp_byte("reg_rdata_q", mdl[a][7:0], reg_rdata_q);
        end
        idle();
    endtask : check_regs

    // Enables all switchers, runs one power-off request and checks its length and effect.
    task automatic run_seq;
        int exp_busy;
        int cnt;
        int dis;
        exp_busy = 0;
        dis      = 0;
        for (int s = 0; s < 3; s++) begin
            exp_busy += 1;
            if (mdl[8'h58 + s][7]) begin
                exp_busy += (mdl[8'h58 + s] & 7) * MSC + 2;
                dis |= mdl[8'h58 + s][6] | (mdl[8'h58 + s][4] << 1) | (mdl[8'h58 + s][3] << 2);
            end
        end
        sw_on_req = 3'b000;
        @(negedge sys_clk);
        sw_on_req = 3'b111;
        repeat (2) @(negedge sys_clk);
        power_off_req = 1'b1;
        @(negedge sys_clk);
        cnt = 0;
        while (seq_busy_q === 1'b1 && cnt < 300) begin
            cnt++;
            power_off_req = (cnt == 2);
            @(negedge sys_clk);
        end
        power_off_req = 1'b0;
        cmp_cnt("busy cycles", exp_busy, cnt);
        cmp_byte("seq_done_q", 8'h01, {7'h0, seq_done_q});
        cmp_byte("sw_en_q", 8'(7 & ~dis), {5'h0, sw_en_q});
        @(negedge sys_clk);
        cmp_byte("seq_done_q", 8'h00, {7'h0, seq_done_q});
    endtask : run_seq

    // ------------------------------------------------------------------------
    // Clock, timeout and main sequence.
    // ------------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        int rc [3];
        int cd [3];
        {rst_n, reg_wr_en, reg_rd_en, power_off_req} = 4'h0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        sw_on_req = 3'b000;
        void'($urandom(41));
        mdl_reset();
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        check_regs();
        for (int a = 8'h57; a <= 8'h5f; a++) wr(pofs_byte_t'(a), pofs_byte_t'($urandom));
        check_regs();
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        mdl_reset();
        check_regs();
        for (int c = 0; c < 8; c++) begin
            cd = '{c, (c + 1) % 8, (c + 2) % 8};
            wr(8'h5d, 8'(cd[0] << 5));
            wr(8'h5e, 8'((cd[1] << 5) | (cd[2] << 1)));
            idle();
            sw_on_req = 3'b111;
            @(negedge sys_clk);
            cmp_byte("sw_en_q", 8'h07, {5'h0, sw_en_q});
            rc = '{0, 0, 0};
            for (int k = 0; k < 200; k++) begin
                for (int i = 0; i < 3; i++) if (sw_ramping[i] === 1'b1) rc[i]++;
                @(negedge sys_clk);
            end
            for (int i = 0; i < 3; i++) cmp_cnt("ramp cycles", ms_tab[cd[i]] * MSC + 1, rc[i]);
            cmp_byte("sw_ready_q", 8'h07, {5'h0, sw_ready_q});
            sw_on_req = 3'b000;
            @(negedge sys_clk);
        end
        run_seq();
        for (int n = 0; n < 6; n++) begin
            for (int s = 0; s < 3; s++) wr(pofs_byte_t'(8'h58 + s), pofs_byte_t'($urandom));
            idle();
            run_seq();
        end
        final_report();
    end

endmodule : power_off_sequence_and_soft_start_cfg_test
